// ---- rtl/sinc3_chop_pkg.sv ----
// Shared constants and the state record of the chopped Sinc3 decimator.
package sinc3_chop_pkg;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_MODE = 8'h00;
	localparam logic [7:0] OFS_DWORD = 8'h04;
	localparam logic [7:0] OFS_CTRL1 = 8'h08;
	localparam logic [7:0] OFS_DATA = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;

	// ------------------------------------------------------------
	// Fields and reset values
	// ------------------------------------------------------------
	localparam int MODE_SWAP_OFF_BIT = 0;
	localparam int CTRL1_BUF_HI_BIT = 7;
	localparam int CTRL1_BUF_LO_BIT = 6;
	localparam int STATUS_READY_BIT = 0;
	localparam int DATA_LSB = 4;
	localparam logic [7:0] DWORD_RST = 8'h45;
	localparam logic [7:0] DWORD_MIN_CHOP = 8'h0D;
	localparam logic [7:0] DWORD_MIN_PLAIN = 8'h03;
	localparam logic [7:0] CTRL1_RST = 8'h00;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int MOD_FREQ_HZ = 32768;
	localparam int DEC_SHIFT = 3;
	localparam logic [1:0] SKIP_CHOP = 2'h2;
	localparam logic [1:0] SETTLE_PLAIN = 2'h2;

	// ------------------------------------------------------------
	// State record
	// ------------------------------------------------------------
	typedef struct packed {
		logic [2:0] mc_sync;
		logic [2:0] mb_sync;
		logic mc_lvl;
		logic [35:0] i1;
		logic [35:0] i2;
		logic [35:0] i3;
		logic [35:0] z0;
		logic [35:0] z1;
		logic [35:0] z2;
		logic [10:0] dec_cnt;
		logic [1:0] skip;
		logic phase;
		logic [35:0] prev;
		logic prev_ok;
		logic [1:0] settle;
		logic mode_off;
		logic [7:0] dword;
		logic [7:0] ctrl1;
		logic [31:0] data;
		logic ready;
		logic done;
		logic aw_ok;
		logic [7:0] aw_addr;
		logic w_ok;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} state_type;

	localparam state_type ST_RESET = '{dword: DWORD_RST, ctrl1: CTRL1_RST,
		skip: SKIP_CHOP, settle: SETTLE_PLAIN, default: '0};

endpackage

// ---- rtl/sinc3_chop_decimator.sv ----
// Sinc3 decimator with two-point chop averaging and an AXI4-Lite slave.
//
// Implementation choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
// Function
// - Decimation equals eight times decimation_word.
// - Chop mode: one result per 24*word clocks.
// - Chop word range 13..255, resets to 69.
// - polarity_swap_off low enables chopping, reset low.
// - Reverse polarity; average new and previous outputs.
// - Reversal runs at half output data rate.
// - Chop: settled result after two conversion periods.
// - Unsynchronised step fully shown in third result.
// - Chop: each word increment adds 0.732 ms period.
// - Buffer off when ctrl1 bit7 set, bit6 clear.
// - Plain mode: result per 8*word, word 3..255.
// - Plain mode: withhold results until third conversion.
module sinc3_chop_decimator
	import sinc3_chop_pkg::*;
(
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic mod_clk,
	input wire logic mod_bit,
	output logic polarity_swap,
	output logic buffer_off,
	output logic conv_done,
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready
);

	state_type st;
	state_type nxt_st;
	logic mod_rise;
	logic [10:0] nlim;
	logic dec_hit;
	logic chop;
	logic [35:0] x_in;
	logic [35:0] y1;
	logic [35:0] y2;
	logic [35:0] y3;
	logic [35:0] val;
	logic [36:0] sum;
	logic [35:0] avg;
	logic take;
	logic publish;
	logic wr_go;
	logic cfg_wr;
	logic data_rd;
	logic [7:0] wbyte;
	logic [7:0] wmin;

	// ------------------------------------------------------------
	// Filter datapath
	// ------------------------------------------------------------
	// The modulator clock agrees across two sync stages before it counts.
	assign mod_rise = (st.mc_sync[2] == st.mc_sync[1]) &&
		(st.mc_sync[1] != st.mc_lvl) && st.mc_sync[1];
	// Every step of the word adds eight modulator clocks per decimation.
	assign nlim = {st.dword, 3'b000};
	assign dec_hit = mod_rise && (st.dec_cnt == nlim - 11'h001);
	assign chop = !st.mode_off;
	assign x_in = st.mb_sync[2] ? 36'h000000001 : 36'hFFFFFFFFF;
	assign y1 = st.i3 - st.z0;
	assign y2 = y1 - st.z1;
	assign y3 = y2 - st.z2;
	// Negative phase outputs are negated so the offset term alternates.
	assign val = st.phase ? (36'h000000000 - y3) : y3;
	assign sum = {val[35], val} + {st.prev[35], st.prev};
	assign avg = sum[36:1];
	assign take = dec_hit && chop && (st.skip == 2'h0);
	assign publish = !cfg_wr && ((take && st.prev_ok) ||
		(dec_hit && !chop && (st.settle == 2'h0)));

	// ------------------------------------------------------------
	// Bus decode
	// ------------------------------------------------------------
	assign wr_go = st.aw_ok && st.w_ok && !st.bvalid;
	assign cfg_wr = wr_go && st.w_strb[0] && ((st.aw_addr == OFS_MODE) ||
		(st.aw_addr == OFS_DWORD) || (st.aw_addr == OFS_CTRL1));
	assign data_rd = arvalid && !st.rvalid && (araddr == OFS_DATA);
	assign wbyte = st.w_data[7:0];
	assign awready = !st.aw_ok;
	assign wready = !st.w_ok;
	assign arready = !st.rvalid;
	assign bvalid = st.bvalid;
	assign bresp = st.bresp;
	assign rvalid = st.rvalid;
	assign rdata = st.rdata;
	assign rresp = st.rresp;
	assign polarity_swap = chop && st.phase;
	assign buffer_off = st.ctrl1[CTRL1_BUF_HI_BIT] &&
		!st.ctrl1[CTRL1_BUF_LO_BIT];
	assign conv_done = st.done;

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb
	begin
		nxt_st = st;
		wmin = DWORD_MIN_PLAIN;
		nxt_st.mc_sync = {st.mc_sync[1:0], mod_clk};
		nxt_st.mb_sync = {st.mb_sync[1:0], mod_bit};
		if ((st.mc_sync[2] == st.mc_sync[1]) &&
			(st.mc_sync[1] != st.mc_lvl))
		begin
			nxt_st.mc_lvl = st.mc_sync[1];
		end
		nxt_st.done = publish;
		if (mod_rise)
		begin
			nxt_st.i1 = st.i1 + x_in;
			nxt_st.i2 = st.i2 + st.i1;
			nxt_st.i3 = st.i3 + st.i2;
			nxt_st.dec_cnt = st.dec_cnt + 11'h001;
		end
		if (dec_hit)
		begin
			nxt_st.dec_cnt = 11'h000;
			nxt_st.z0 = st.i3;
			nxt_st.z1 = y1;
			nxt_st.z2 = y2;
			if (chop)
			begin
				if (st.skip != 2'h0)
				begin
					// Outputs straddling a reversal are not yet settled.
					nxt_st.skip = st.skip - 2'h1;
				end
				else
				begin
					nxt_st.prev = val;
					nxt_st.prev_ok = 1'b1;
					nxt_st.phase = !st.phase;
					nxt_st.skip = SKIP_CHOP;
					if (st.prev_ok)
					begin
						nxt_st.data = avg[DATA_LSB +: 32];
					end
				end
			end
			else if (st.settle != 2'h0)
			begin
				nxt_st.settle = st.settle - 2'h1;
			end
			else
			begin
				nxt_st.data = y3[DATA_LSB +: 32];
			end
		end
		// Data read clears ready; a result in the same cycle wins.
		if (data_rd)
		begin
			nxt_st.ready = 1'b0;
		end
		if (publish)
		begin
			nxt_st.ready = 1'b1;
		end
		if (awvalid && !st.aw_ok)
		begin
			nxt_st.aw_ok = 1'b1;
			nxt_st.aw_addr = awaddr;
		end
		if (wvalid && !st.w_ok)
		begin
			nxt_st.w_ok = 1'b1;
			nxt_st.w_data = wdata;
			nxt_st.w_strb = wstrb;
		end
		if (wr_go)
		begin
			nxt_st.bvalid = 1'b1;
			nxt_st.bresp = RESP_OKAY;
			if (st.aw_addr == OFS_MODE)
			begin
				if (st.w_strb[0])
				begin
					nxt_st.mode_off = wbyte[MODE_SWAP_OFF_BIT];
				end
			end
			else if (st.aw_addr == OFS_DWORD)
			begin
				if (st.w_strb[0])
				begin
					nxt_st.dword = wbyte;
				end
			end
			else if (st.aw_addr == OFS_CTRL1)
			begin
				if (st.w_strb[0])
				begin
					nxt_st.ctrl1 = wbyte;
				end
			end
			else if ((st.aw_addr != OFS_DATA) &&
				(st.aw_addr != OFS_STATUS))
			begin
				nxt_st.bresp = RESP_SLVERR;
			end
		end
		if (st.bvalid && bready)
		begin
			nxt_st.bvalid = 1'b0;
			nxt_st.aw_ok = 1'b0;
			nxt_st.w_ok = 1'b0;
		end
		// Out-of-range words are raised to the floor of the active mode.
		if (!nxt_st.mode_off)
		begin
			wmin = DWORD_MIN_CHOP;
		end
		if (nxt_st.dword < wmin)
		begin
			nxt_st.dword = wmin;
		end
		// A programming change restarts decimation and the average.
		if (cfg_wr)
		begin
			nxt_st.dec_cnt = 11'h000;
			nxt_st.prev_ok = 1'b0;
			nxt_st.skip = SKIP_CHOP;
			nxt_st.settle = SETTLE_PLAIN;
		end
		if (arvalid && !st.rvalid)
		begin
			nxt_st.rvalid = 1'b1;
			nxt_st.rresp = RESP_OKAY;
			nxt_st.rdata = 32'h00000000;
			if (araddr == OFS_MODE)
			begin
				nxt_st.rdata[MODE_SWAP_OFF_BIT] = st.mode_off;
			end
			else if (araddr == OFS_DWORD)
			begin
				nxt_st.rdata[7:0] = st.dword;
			end
			else if (araddr == OFS_CTRL1)
			begin
				nxt_st.rdata[7:0] = st.ctrl1;
			end
			else if (araddr == OFS_DATA)
			begin
				nxt_st.rdata = st.data;
			end
			else if (araddr == OFS_STATUS)
			begin
				nxt_st.rdata[STATUS_READY_BIT] = st.ready;
			end
			else
			begin
				nxt_st.rresp = RESP_SLVERR;
			end
		end
		else if (st.rvalid && rready)
		begin
			nxt_st.rvalid = 1'b0;
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			st <= ST_RESET;
		end
		else
		begin
			st <= nxt_st;
		end
	end

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	sequence s_cfg_change;
		cfg_wr;
	endsequence

	sequence s_chop_take;
		take && !cfg_wr;
	endsequence

	a_reset_values: assert property (@(posedge aclk) disable iff (1'b0)
		(!aresetn ##1 aresetn) |-> (st.dword == DWORD_RST && !st.mode_off))
		else $error("Reset values of mode or word are wrong.");

	a_chop_floor: assert property (chop |-> st.dword >= DWORD_MIN_CHOP)
		else $error("Chop word below its floor.");

	a_plain_floor: assert property (st.dword >= DWORD_MIN_PLAIN)
		else $error("Word below the plain floor.");

	a_decim_step: assert property ((mod_rise && !dec_hit && !cfg_wr)
		|=> st.dec_cnt == $past(st.dec_cnt) + 11'h001 &&
		st.dec_cnt < nlim)
		else $error("Decimation counter stepped wrongly.");

	a_chop_reverse: assert property (s_chop_take
		|=> st.skip == SKIP_CHOP && st.phase != $past(st.phase))
		else $error("Reversal or settle skip missing.");

	a_chop_average: assert property ((s_chop_take and st.prev_ok)
		|=> st.done && st.ready && st.data == $past(avg[DATA_LSB +: 32]))
		else $error("Average result not written.");

	a_first_held: assert property ((s_chop_take and !st.prev_ok)
		|=> !st.done ##1 (!st.done throughout (st.skip != 2'h0)))
		else $error("Result issued before two conversions.");

	a_change_clear: assert property (s_cfg_change
		|=> !st.prev_ok && st.dec_cnt == 11'h000 && st.skip == SKIP_CHOP &&
		st.settle == SETTLE_PLAIN)
		else $error("Programming change did not restart filter.");

	a_plain_hold: assert property ((dec_hit && !chop && !cfg_wr &&
		st.settle != 2'h0) |=> !st.done && st.settle == $past(st.settle) - 2'h1)
		else $error("Plain result issued before settling.");

	a_buffer_off: assert property ((cfg_wr && st.aw_addr == OFS_CTRL1 &&
		wbyte[7:6] == 2'b10) |=> buffer_off ##1 buffer_off)
		else $error("Buffer not disabled.");

	a_ready_wins: assert property (publish |=> st.ready)
		else $error("Ready lost on same-cycle read.");

endmodule

// ---- verif/mod_source.sv ----
// Behavioural sigma-delta modulator feeding the decimator.
`timescale 1ns/1ps
module mod_source
#(
	parameter int HALF_NS = 20
)
(
	input wire logic polarity_swap,
	input wire logic level,
	output logic mod_clk,
	output logic mod_bit
);
	// The sampling clock runs free; it is scaled up to keep runs short.
	initial
	begin
		mod_clk = 1'b0;
		mod_bit = 1'b0;
	end
	always #HALF_NS mod_clk = ~mod_clk;
	// Reversed inputs invert the bit that the filter sees.
	always @(negedge mod_clk)
		mod_bit <= level ^ polarity_swap;
endmodule

// ---- verif/sinc3_chop_decimator_test.sv ----
// Self-checking bench for the chopped Sinc3 decimator.
`timescale 1ns/1ps
module sinc3_chop_decimator_test
	import sinc3_chop_pkg::*;
;
	localparam int MP = 8;
	logic aclk, aresetn, level, mod_clk, mod_bit, polarity_swap;
	logic buffer_off, conv_done, awvalid, awready, wvalid, wready;
	logic bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, v;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	int bad_count, checks, cyc;

	sinc3_chop_decimator DUT (.aclk, .aresetn, .mod_clk, .mod_bit,
		.polarity_swap, .buffer_off, .conv_done, .awaddr, .awvalid,
		.awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid,
		.bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid,
		.rready);
	mod_source modulator (.polarity_swap, .level, .mod_clk, .mod_bit);

	always #2.5 aclk = ~aclk;
	always @(posedge aclk)
		cyc <= cyc + 1;

	// ------------------------------------------------------------
	// Bus and check tasks
	// ------------------------------------------------------------
	task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
		checks++;
		if (got !== exp)
		begin
			bad_count++;
			$display("unexpected at %0t: %s", $time, m);
		end
	endtask

	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
		int n;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end
		while (bvalid !== 1'b1 && n < 50);
		bready <= 1'b0;
		if (n >= 50)
			chk(32'h0, 32'h1, "write timeout");
		chk(32'(bresp), 32'(e), "write response");
	endtask

	task rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
			if (arready)
				arvalid <= 1'b0;
		end
		while (rvalid !== 1'b1 && n < 50);
		rready <= 1'b0;
		v = rdata;
		chk(32'(rresp), 32'(er), "read response");
		if (n >= 50)
			chk(32'h0, 32'h1, "read timeout");
		// Results may lose up to three counts at a reversal edge, so data is banded.
		if (er === RESP_OKAY && a === OFS_DATA)
			chk(32'(v > e - 32'h4 && v <= e), 32'h1, "read data");
		else if (er === RESP_OKAY)
			chk(v, e, "read data");
	endtask

	task wdone(output int t);
		int n;
		n = 0;
		do
		begin
			@(posedge aclk);
			n++;
		end
		while (conv_done !== 1'b1 && n < 8000);
		t = cyc;
		if (n >= 8000)
			chk(32'h0, 32'h1, "no result");
	endtask

	task lat(input int d, input int l);
		chk(32'(d >= l - 8 && d <= l + 24), 32'h1, "settling time");
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task s_reset;
		rd(OFS_MODE, 32'h0, RESP_OKAY);
		rd(OFS_DWORD, 32'h45, RESP_OKAY);
		rd(8'h14, 32'h0, RESP_SLVERR);
		chk(32'(polarity_swap), 32'h0, "swap at reset");
	endtask

	task s_buffer;
		logic [7:0] c [4] = '{8'h80, 8'hC0, 8'h40, 8'h00};
		for (int i = 0; i < 4; i++)
		begin
			axw(OFS_CTRL1, {24'h0, c[i]}, RESP_OKAY);
			chk(32'(buffer_off), 32'(c[i] == 8'h80), "buffer");
		end
		axw(8'h18, 32'h1, RESP_SLVERR);
	endtask

	task s_chop;
		int t0, t1, t2, p;
		logic sw;
		axw(OFS_DWORD, 32'h0C, RESP_OKAY);
		rd(OFS_DWORD, 32'h0D, RESP_OKAY);
		t0 = cyc;
		wdone(t1);
		lat(t1 - t0, 6 * 104 * MP);
		sw = polarity_swap;
		wdone(t2);
		p = t2 - t1;
		chk(32'(p), 32'(24 * 13 * MP), "chop period");
		chk(32'(polarity_swap ^ sw), 32'h1, "reversal");
		rd(OFS_STATUS, 32'h1, RESP_OKAY);
		rd(OFS_DATA, 32'h112A0, RESP_OKAY);
		chk(32'(v > 32'h1129C && v <= 32'h112A0), 32'h1, "average");
		rd(OFS_STATUS, 32'h0, RESP_OKAY);
		axw(OFS_DWORD, 32'hFF, RESP_OKAY);
		rd(OFS_DWORD, 32'hFF, RESP_OKAY);
		axw(OFS_DWORD, 32'h0E, RESP_OKAY);
		wdone(t1);
		wdone(t2);
		chk(32'(t2 - t1 - p), 32'(24 * MP), "word step");
	endtask

	task s_plain;
		int t0, t1, t2;
		axw(OFS_MODE, 32'h1, RESP_OKAY);
		axw(OFS_DWORD, 32'h3, RESP_OKAY);
		t0 = cyc;
		wdone(t1);
		lat(t1 - t0, 3 * 24 * MP);
		wdone(t2);
		chk(32'(t2 - t1), 32'(8 * 3 * MP), "plain period");
		chk(32'(polarity_swap), 32'h0, "no reversal");
		rd(OFS_DATA, 32'h360, RESP_OKAY);
		chk(32'(v > 32'h35C && v <= 32'h360), 32'h1, "plain data");
		axw(OFS_DWORD, 32'h2, RESP_OKAY);
		rd(OFS_DWORD, 32'h3, RESP_OKAY);
		axw(OFS_MODE, 32'h0, RESP_OKAY);
		rd(OFS_DWORD, 32'h0D, RESP_OKAY);
	endtask

	task close_out;
		$display("checks %0d, mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	initial
	begin
		{aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, wdata, cyc, bad_count, checks} = '0;
		wstrb = 4'hF;
		level = 1'b1;
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		s_reset;
		s_buffer;
		s_chop;
		s_plain;
		close_out;
	end

	// Generous margin over the roughly 16500 cycles that the run needs.
	initial
	begin
		#300000;
		bad_count++;
		close_out;
	end
endmodule
